// >>> accumulator_alu_pkg.sv
package accumulator_alu_pkg;

	localparam int ACC_WIDTH = 32;
	localparam int HALF_WIDTH = 16;
	localparam int OPCODE_WIDTH = 4;

	// Opcode encodings seen on the opcode port
	localparam logic [3:0] load_accumulator_op = 4'h0;
	localparam logic [3:0] unsigned_subtract_op = 4'h1;
	localparam logic [3:0] long_subtract_op = 4'h2;
	localparam logic [3:0] unsigned_multiply_op = 4'h3;
	localparam logic [3:0] unsigned_divide_op = 4'h4;
	localparam logic [3:0] bit_count_op = 4'h5;
	localparam logic [3:0] shift_toward_msb_op = 4'h6;
	localparam logic [3:0] shift_toward_lsb_op = 4'h7;
	localparam logic [3:0] bit_position_to_index_op = 4'h8;
	localparam logic [3:0] index_to_onehot_op = 4'h9;

	// Reset values
	localparam logic [31:0] ACC_RESET = 32'h00000000;
	localparam logic [31:0] STACK_RESET = 32'h00000000;
	localparam logic FLAG_RESET = 1'b0;

	// Field positions
	localparam int SIGN_BIT = 31;
	localparam int SHIFT_COUNT_WIDTH = 6;
	localparam int INDEX_WIDTH = 5;
	localparam logic [31:0] INDEX_LIMIT = 32'h0000001f;
	localparam int INDEX_REDUCE_STEPS = 7;

endpackage

// >>> divide_if.sv
`timescale 1ns/1ps
interface divide_if #(parameter int WIDTH = 16);
	logic start;
	logic [WIDTH-1:0] dividend;
	logic [WIDTH-1:0] divisor;
	logic done;
	logic [WIDTH-1:0] quotient;
	logic [WIDTH-1:0] remainder;

	modport requester (output start, output dividend, output divisor,
		input done, input quotient, input remainder);
	modport engine (input start, input dividend, input divisor,
		output done, output quotient, output remainder);
endinterface

// >>> unsigned_serial_divider.sv
`timescale 1ns/1ps
module unsigned_serial_divider #(
	parameter int WIDTH = 16
) (
	input wire logic clock,
	input wire logic sys_rst,
	divide_if.engine div
);
	typedef enum logic {div_idle, div_run} div_state_e;

	div_state_e state_reg;
	logic [WIDTH-1:0] rem_reg;
	logic [WIDTH-1:0] quo_reg;
	logic [$clog2(WIDTH+1)-1:0] count_reg;
	logic done_reg;
	// Divisor held for the whole run; the operand bus may move meanwhile
	logic [WIDTH-1:0] dvs_reg;

	// One restoring step per clock
	wire [WIDTH:0] shifted = {rem_reg, quo_reg[WIDTH-1]};
	wire [WIDTH:0] trial = shifted - {1'b0, dvs_reg};
	wire fits = ~trial[WIDTH];
	wire last_step = (count_reg == 1);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= div_idle;
			rem_reg <= '0;
			quo_reg <= '0;
			dvs_reg <= '0;
			count_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				div_idle: begin
					if (div.start) begin
						rem_reg <= '0;
						quo_reg <= div.dividend;
						dvs_reg <= div.divisor;
						count_reg <= ($clog2(WIDTH+1))'(WIDTH);
						state_reg <= div_run;
					end
				end
				div_run: begin
					rem_reg <= fits ? trial[WIDTH-1:0] : shifted[WIDTH-1:0];
					quo_reg <= {quo_reg[WIDTH-2:0], fits};
					count_reg <= count_reg - 1'b1;
					if (last_step) begin
						done_reg <= 1'b1;
						state_reg <= div_idle;
					end
				end
				default: state_reg <= div_idle;
			endcase
		end
	end

	assign div.done = done_reg;
	assign div.quotient = quo_reg;
	assign div.remainder = rem_reg;
endmodule

// >>> accumulator_bit_ops.sv
`timescale 1ns/1ps
module accumulator_bit_ops #(
	parameter int WIDTH = 32
) (
	input wire logic [WIDTH-1:0] value,
	output logic [5:0] ones_count,
	output logic [4:0] low_index,
	output logic multi_set,
	output logic [WIDTH-1:0] onehot
);
	logic [31:0] reduced;

	always_comb begin
		ones_count = 6'h00;
		low_index = 5'h00;
		reduced = value;
		for (int i = 0; i < WIDTH; i++) begin
			ones_count = ones_count + 6'(value[i]);
		end
		// Scan from the top so the lowest set bit wins
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (value[i]) begin
				low_index = 5'(i);
			end
		end
		// Divide by 32 until the value fits in five bits
		for (int k = 0; k < accumulator_alu_pkg::INDEX_REDUCE_STEPS; k++) begin
			if (reduced > accumulator_alu_pkg::INDEX_LIMIT) begin
				reduced = reduced >> accumulator_alu_pkg::INDEX_WIDTH;
			end
		end
	end

	assign multi_set = (ones_count > 6'h01);
	assign onehot = WIDTH'(1) << reduced[4:0];
endmodule

// >>> accumulator_binary_alu.sv
// Function
// - Subtract a 16-bit operand; difference lands in the accumulator.
// - 16-bit subtract needing a borrow sets the short borrow flag.
// - 32-bit subtract needing a borrow sets the long borrow flag.
// - Zero flag set when the result is zero, cleared otherwise; load and decode leave it unchanged.
// - Negative flag set when resulting accumulator is negative, except after load, bit count or decode, which leave it unchanged.
// - Flags hold until a later operation owning that flag rewrites it.
// - Multiply 16-bit operand by accumulator; full 32-bit product kept.
// - Divide: quotient to accumulator, remainder to first stack level.
// - Divide sets range flag for an operand it cannot handle.
// - Bit count replaces accumulator with number of one bits.
// - Left shift by 1 to 32, zero fill, top bits discarded.
// - Right shift by 1 to 32, zero fill, bottom bits lost.
// - Encode gives the set bit position; bit 31 gives 1f.
// - Encode of 0000 or 0001 yields zero.
// - Several set bits: encode lowest one and set operand range flag.
// - Decode of value 0 to 31 sets that bit position.
// - Decode of value f sets bit 15.
// - Decode input above 31 divided by 32 until below 32.
// - 16-bit arithmetic uses the low 16 accumulator bits as its operand.
`timescale 1ns/1ps
module accumulator_binary_alu #(
	parameter int ACC_WIDTH = 32,
	parameter int HALF_WIDTH = 16
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [3:0] opcode,
	input wire logic [31:0] operand,
	output logic busy,
	output logic done,
	output logic [31:0] accumulator,
	output logic [31:0] stack_level1,
	output logic zero_result_flag,
	output logic negative_result_flag,
	output logic short_borrow_flag,
	output logic long_borrow_flag,
	output logic operand_range_flag
);
	typedef enum logic {alu_ready, alu_dividing} alu_state_e;

	alu_state_e state_reg;
	logic [31:0] acc_reg;
	logic [31:0] stack_reg;
	logic zero_reg;
	logic neg_reg;
	logic sborrow_reg;
	logic lborrow_reg;
	logic range_reg;
	logic done_reg;

	divide_if #(.WIDTH(HALF_WIDTH)) div_link ();

	wire [5:0] ones_count;
	wire [4:0] low_index;
	wire multi_set;
	wire [31:0] onehot;

	accumulator_bit_ops #(.WIDTH(ACC_WIDTH)) bit_ops (
		.value(acc_reg),
		.ones_count(ones_count),
		.low_index(low_index),
		.multi_set(multi_set),
		.onehot(onehot)
	);

	unsigned_serial_divider #(.WIDTH(HALF_WIDTH)) divider (
		.clock(clock),
		.sys_rst(sys_rst),
		.div(div_link.engine)
	);

	// Instruction decode
	wire accept = start && (state_reg == alu_ready);
	wire is_load = (opcode == accumulator_alu_pkg::load_accumulator_op);
	wire is_sub = (opcode == accumulator_alu_pkg::unsigned_subtract_op);
	wire is_lsub = (opcode == accumulator_alu_pkg::long_subtract_op);
	wire is_mul = (opcode == accumulator_alu_pkg::unsigned_multiply_op);
	wire is_div = (opcode == accumulator_alu_pkg::unsigned_divide_op);
	wire is_sum = (opcode == accumulator_alu_pkg::bit_count_op);
	wire is_shl = (opcode == accumulator_alu_pkg::shift_toward_msb_op);
	wire is_shr = (opcode == accumulator_alu_pkg::shift_toward_lsb_op);
	wire is_enc = (opcode == accumulator_alu_pkg::bit_position_to_index_op);
	wire is_dec = (opcode == accumulator_alu_pkg::index_to_onehot_op);

	// 16-bit arithmetic sees only the low half of the accumulator
	wire [15:0] acc_low = acc_reg[15:0];
	wire [15:0] op_low = operand[15:0];
	wire div_by_zero = (op_low == 16'h0000);
	wire div_launch = accept && is_div && !div_by_zero;

	// Result candidates
	wire [31:0] sub_result = {16'h0000, acc_low} - {16'h0000, op_low};
	wire sub_borrow = (acc_low < op_low);
	wire [31:0] lsub_result = acc_reg - operand;
	wire lsub_borrow = (acc_reg < operand);
	wire [31:0] mul_result = {16'h0000, acc_low} * {16'h0000, op_low};
	wire [5:0] shift_count = operand[5:0];
	wire [31:0] shl_result = acc_reg << shift_count;
	wire [31:0] shr_result = acc_reg >> shift_count;
	wire [31:0] div_quotient = {16'h0000, div_link.quotient};
	wire [31:0] div_remainder = {16'h0000, div_link.remainder};

	// Single-cycle result mux; divide by zero leaves the accumulator alone
	wire [31:0] quick_result =
		is_load ? operand :
		is_sub ? sub_result :
		is_lsub ? lsub_result :
		is_mul ? mul_result :
		is_sum ? {26'h0, ones_count} :
		is_shl ? shl_result :
		is_shr ? shr_result :
		is_enc ? {27'h0, low_index} :
		is_dec ? onehot :
		acc_reg;

	wire quick_commit = accept && !div_launch;
	wire div_commit = div_link.done && (state_reg == alu_dividing);
	wire [31:0] acc_next = div_commit ? div_quotient : quick_result;

	// Which flags this instruction owns; others keep their value
	wire upd_zn = is_sub || is_lsub || is_mul || is_div || is_shl ||
		is_shr || is_enc;
	wire upd_zero = upd_zn || is_sum;
	wire upd_range = is_div || is_enc;

	wire zero_next = (acc_next == accumulator_alu_pkg::ACC_RESET);
	wire neg_next = acc_next[accumulator_alu_pkg::SIGN_BIT];
	wire range_next = is_div ? div_by_zero : multi_set;

	assign div_link.start = div_launch;
	assign div_link.dividend = acc_low;
	assign div_link.divisor = op_low;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= alu_ready;
		end else if (div_launch) begin
			state_reg <= alu_dividing;
		end else if (div_commit) begin
			state_reg <= alu_ready;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			acc_reg <= accumulator_alu_pkg::ACC_RESET;
			stack_reg <= accumulator_alu_pkg::STACK_RESET;
			done_reg <= 1'b0;
		end else begin
			done_reg <= quick_commit || div_commit;
			if (quick_commit) begin
				acc_reg <= quick_result;
			end else if (div_commit) begin
				acc_reg <= div_quotient;
				stack_reg <= div_remainder;
			end
			if (quick_commit && is_load) begin
				stack_reg <= acc_reg;
			end
		end
	end

	// Flags change only on instructions that own them
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			zero_reg <= accumulator_alu_pkg::FLAG_RESET;
			neg_reg <= accumulator_alu_pkg::FLAG_RESET;
			sborrow_reg <= accumulator_alu_pkg::FLAG_RESET;
			lborrow_reg <= accumulator_alu_pkg::FLAG_RESET;
			range_reg <= accumulator_alu_pkg::FLAG_RESET;
		end else if (div_commit) begin
			zero_reg <= zero_next;
			neg_reg <= neg_next;
			range_reg <= 1'b0;
		end else if (quick_commit) begin
			if (upd_zero) begin
				zero_reg <= zero_next;
			end
			if (upd_zn) begin
				neg_reg <= neg_next;
			end
			if (is_sub) begin
				sborrow_reg <= sub_borrow;
			end
			if (is_lsub) begin
				lborrow_reg <= lsub_borrow;
			end
			if (upd_range) begin
				range_reg <= range_next;
			end
		end
	end

	assign busy = (state_reg == alu_dividing);
	assign done = done_reg;
	assign accumulator = acc_reg;
	assign stack_level1 = stack_reg;
	assign zero_result_flag = zero_reg;
	assign negative_result_flag = neg_reg;
	assign short_borrow_flag = sborrow_reg;
	assign long_borrow_flag = lborrow_reg;
	assign operand_range_flag = range_reg;
endmodule

// >>> operand_memory.sv
`timescale 1ns/1ps
module operand_memory (
	input wire logic [3:0] addr,
	input wire logic valid,
	output logic [31:0] data
);
	logic [31:0] words [16];
	initial begin
		words = '{32'h0, 32'h1, 32'h2, 32'h3, 32'hf, 32'h20, 32'h28,
			32'hffff, 32'h80000000, 32'h12345678, 32'h0, 32'h0, 32'h0,
			32'h0, 32'h0, 32'h0};
	end
	// Outside a request the bus shows garbage, not the last word
	assign data = valid ? words[addr] : ~words[addr];
endmodule

// >>> alu_monitor.sv
`timescale 1ns/1ps
module alu_monitor (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [3:0] opcode,
	input wire logic [31:0] operand,
	input wire logic busy,
	input wire logic done,
	input wire logic [31:0] accumulator,
	input wire logic [31:0] stack_level1,
	input wire logic zero_result_flag,
	input wire logic negative_result_flag,
	input wire logic short_borrow_flag,
	input wire logic long_borrow_flag,
	input wire logic operand_range_flag
);
	logic [31:0] acc_q;
	logic [31:0] opd_q;
	logic [4:0] st;
	assign st = {zero_result_flag, negative_result_flag, short_borrow_flag,
		long_borrow_flag, operand_range_flag};
	always_ff @(posedge clock) begin
		acc_q <= accumulator;
		opd_q <= operand;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence take(logic [3:0] op);
		start && !busy && opcode == op;
	endsequence
	sequence div_go(logic by_zero);
		take(accumulator_alu_pkg::unsigned_divide_op)
			##0 ((operand[15:0] == 16'h0) == by_zero);
	endsequence
	AST_DONE_ONE: assert property (done && !(start && !busy)
		|=> !done) else $error("done too long");
	AST_WRITE_DONE: assert property (!$past(sys_rst) &&
		($changed(st) || $changed(accumulator) || $changed(stack_level1))
		|-> ##[0:1] done) else $error("write without done");
	AST_ZERO: assert property (!$past(sys_rst) &&
		$changed(zero_result_flag) |->
		zero_result_flag == (accumulator == 32'h0)) else $error("zero");
	AST_NEG: assert property (!$past(sys_rst) &&
		$changed(negative_result_flag) |->
		negative_result_flag == accumulator[31]) else $error("negative");
	AST_SUB: assert property (take(4'h1) |=>
		accumulator == {16'h0, acc_q[15:0]} - {16'h0, opd_q[15:0]} &&
		short_borrow_flag == (acc_q[15:0] < opd_q[15:0])) else $error("sub");
	AST_LONG: assert property (take(4'h2) |=>
		long_borrow_flag == (acc_q < opd_q)) else $error("long borrow");
	AST_MUL: assert property (take(4'h3) |=>
		accumulator == acc_q[15:0] * opd_q[15:0]) else $error("mul");
	AST_DIV_RUN: assert property (div_go(1'b0) |=>
		busy [*8] ##1 busy [*8] ##1 busy ##1 (!busy && done))
		else $error("divide length");
	AST_DIV_ZERO: assert property (div_go(1'b1) |=>
		operand_range_flag && accumulator == acc_q) else $error("div zero");
	AST_SHL: assert property (take(4'h6) |=>
		accumulator == acc_q << opd_q[5:0]) else $error("shift");
endmodule
bind accumulator_binary_alu alu_monitor i_monitor (.clock, .sys_rst, .start,
	.opcode, .operand, .busy, .done, .accumulator, .stack_level1,
	.zero_result_flag, .negative_result_flag, .short_borrow_flag,
	.long_borrow_flag, .operand_range_flag);

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic start = 1'b0;
	logic [3:0] opcode = 4'h0;
	logic [3:0] addr = 4'h0;
	logic [31:0] operand;
	logic busy, done, zf, nf, sbf, lbf, rf;
	logic [31:0] acc;
	logic [31:0] stk;
	logic [4:0] fl;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	assign fl = {zf, nf, sbf, lbf, rf};
	always #10 clock = ~clock;
	operand_memory i_mem (.addr(addr), .valid(start), .data(operand));
	accumulator_binary_alu i_dut (.clock(clock), .sys_rst(sys_rst),
		.start(start), .opcode(opcode), .operand(operand), .busy(busy),
		.done(done), .accumulator(acc), .stack_level1(stk),
		.zero_result_flag(zf), .negative_result_flag(nf),
		.short_borrow_flag(sbf), .long_borrow_flag(lbf),
		.operand_range_flag(rf));
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One request, then wait for its completion pulse
	task automatic op(logic [3:0] code, logic [3:0] a);
		int n;
		@(posedge clock) #1;
		start = 1'b1;
		opcode = code;
		addr = a;
		@(posedge clock) #1;
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clock) #1;
			n++;
		end
		chk("done", done, 1'b1);
	endtask
	task automatic ld(logic [3:0] a);
		op(accumulator_alu_pkg::load_accumulator_op, a);
	endtask
	task automatic t_sub();
		ld(4'h9);
		op(4'h1, 4'h1);
		chk("acc", acc, 32'h5677);
		chk("fl", fl, 5'h00);
		ld(4'h3);
		op(4'h1, 4'h3);
		chk("fl", fl, 5'h10);
		op(4'h1, 4'h1);
		chk("acc", acc, 32'hffffffff);
		chk("fl", fl, 5'h0c);
		ld(4'h1);
		op(4'h2, 4'h2);
		chk("acc", acc, 32'hffffffff);
		chk("fl", fl, 5'h0e);
		$display("subtract test done");
	endtask
	task automatic t_muldiv();
		ld(4'h7);
		op(4'h3, 4'h7);
		chk("acc", acc, 32'hfffe0001);
		ld(4'h9);
		op(4'h3, 4'h2);
		chk("acc", acc, 32'hacf0);
		ld(4'h6);
		op(4'h4, 4'h3);
		chk("acc", acc, 32'hd);
		chk("stk", stk, 32'h1);
		chk("busy", busy, 1'b0);
		chk("fl", fl, 5'h06);
		op(4'h4, 4'h0);
		chk("acc", acc, 32'hd);
		chk("fl", fl, 5'h07);
		$display("multiply divide test done");
	endtask
	task automatic t_bits();
		ld(4'h9);
		op(4'h5, 4'h0);
		chk("acc", acc, 32'hd);
		ld(4'h0);
		op(4'h5, 4'h0);
		chk("zf", zf, 1'b1);
		ld(4'h1);
		op(4'h6, 4'h5);
		chk("acc", acc, 32'h0);
		ld(4'h8);
		op(4'h7, 4'h1);
		chk("acc", acc, 32'h40000000);
		op(4'h6, 4'h1);
		chk("nf", nf, 1'b1);
		op(4'h7, 4'h5);
		chk("acc", acc, 32'h0);
		$display("bit count and shift test done");
	endtask
	task automatic t_code();
		ld(4'h8);
		op(4'h8, 4'h0);
		chk("acc", acc, 32'h1f);
		chk("rf", rf, 1'b0);
		ld(4'h1);
		op(4'h8, 4'h0);
		chk("acc", acc, 32'h0);
		ld(4'h6);
		op(4'h8, 4'h0);
		chk("acc", acc, 32'h3);
		chk("rf", rf, 1'b1);
		ld(4'h4);
		op(4'h9, 4'h0);
		chk("acc", acc, 32'h8000);
		ld(4'h6);
		op(4'h9, 4'h0);
		chk("acc", acc, 32'h2);
		ld(4'h2);
		op(4'h9, 4'h0);
		chk("acc", acc, 32'h4);
		ld(4'h9);
		op(4'h1, 4'h1);
		chk("sbf", sbf, 1'b0);
		op(4'h2, 4'h1);
		chk("acc", acc, 32'h5676);
		chk("lbf", lbf, 1'b0);
		$display("encode decode test done");
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (16) @(posedge clock);
		#1 sys_rst = 1'b0;
		chk("acc", acc, 32'h0);
		chk("fl", fl, 5'h00);
		t_sub();
		t_muldiv();
		t_bits();
		t_code();
		tally_and_finish();
	end
endmodule
